// >>> hdl/otp_array_store.sv
`timescale 1ns/1ps
`include "otp_map.svh"

module otp_array_store
  import otp_pkg::*;
#(
  parameter int DEPTH = 6206,
  parameter int ADDR_W = 13
)(
  // Clock
  input wire logic clk_i,
  // Controller side
  array_port_if.store port
);

  // Whole array in flip-flops
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } store_s;

  // Starts erased; no reset touches it, like the real cells
  store_s st_r = '0;
  store_s st_nxt;

  // Programming can only set bits, never clear them
  always_comb
  begin
    st_nxt = st_r;
    if (port.wr_en && int'(port.wr_addr) < DEPTH)
    begin
      st_nxt.mem[port.wr_addr] = st_r.mem[port.wr_addr] | port.wr_data; // RULE2
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  // Out-of-range addresses read as erased
  assign port.rd_data = (int'(port.rd_addr) < DEPTH) ? st_r.mem[port.rd_addr] : `ERASED_BYTE; // RULE1

endmodule

// >>> hdl/otp_eprom_program_control.sv
`timescale 1ns/1ps
`include "otp_map.svh"

// Operation
// RULE1 - Erased array byte reads as zero
// RULE2 - Programming only sets bits to one
// RULE3 - Small variant: four bytes, two low bits
// RULE4 - Large variant: sixteen bytes, four low bits
// RULE5 - No code fetch from array while latched
// RULE6 - Supply raised only after program enable set
// RULE7 - Reads while latched give no stored data
// RULE8 - No vector fetch while latched
// RULE9 - No boot firmware execution while latched
// RULE10 - Clearing latch also clears program enable
// RULE11 - Stop mode forces array to read mode
// RULE12 - Protect bit blocks main array programming
// RULE13 - Protect does not cover secondary array
// RULE14 - Power-on hold: 16 or 4064 cycles
// RULE15 - Watchdog after reset per option, not boot
// RULE16 - Options writable only in boot mode, nonvolatile
// RULE17 - Option bit 7 always reads zero
// RULE18 - Pull-down bits enable port pull-downs
// RULE19 - Watchdog-in-wait bit: one means runs
module otp_eprom_program_control
  import otp_pkg::*;
#(
  parameter int DEPTH = 6206,
  parameter int ADDR_W = 13,
  parameter int GROUP_BITS = 2,
  parameter int SEC_BASE = 5950,
  parameter int SEC_SIZE = 256
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core and pins
  input wire logic stop_i,
  input wire logic boot_mode_i,
  input wire logic programming_supply_i,
  // Status to the core and pins
  output logic fetch_block_o,
  output logic program_active_o,
  output logic ext_clk_out_en_o,
  output logic por_reset_n_o,
  output logic watchdog_run_o,
  output logic watchdog_in_wait_o,
  output logic portb_pulldown_enable_o,
  output logic portc_pulldown_enable_o
);

  // Bytes programmed together in one group
  localparam int GROUP = 1 << GROUP_BITS;

  // All state of the controller
  typedef struct packed {
    prog_e state;                          // Array mode
    logic external_clock_out_enable;                            // Clock-out enable bit
    opt_s opt;                             // Nonvolatile options
    logic [ADDR_W-1:0] addr;               // Array address pointer
    logic [GROUP-1:0][7:0] gbuf;           // Latched group data
    logic [GROUP-1:0] vld;                 // Latched byte valid
    logic [ADDR_W-GROUP_BITS-1:0] base;    // Shared upper address
    logic [GROUP_BITS-1:0] burn_idx;       // Byte being programmed
    logic grp_err;                         // Byte outside group refused
    logic prot_err;                        // Protected byte refused
    logic [1:0] sup_sync;                  // Supply pin synchroniser
    logic [1:0] boot_sync;                 // Boot pin synchroniser
    logic [11:0] por_cnt;                  // Power-on hold counter
    logic por_n;                           // Reset pin released
    logic wdog;                            // Watchdog running
    logic ack;                             // Bus answer
    logic [7:0] rdat;                      // Bus read byte
    logic fetch_blk;                       // Fetch block output
    logic pgm_on;                          // Program active output
  } ctl_s;

  // Options power up erased and survive every reset
  ctl_s st_r = '0;
  ctl_s st_nxt;

  // Port to the array storage
  array_port_if #(.ADDR_W(ADDR_W)) aport ();

  // Storage of the array itself
  otp_array_store #(
    .DEPTH(DEPTH),
    .ADDR_W(ADDR_W)
  ) u_store (
    .clk_i(clk_i),
    .port(aport)
  );

  // Secondary array range check
  function automatic logic in_sec(input logic [ADDR_W-1:0] a);
    in_sec = (int'(a) >= SEC_BASE) && (int'(a) < SEC_BASE + SEC_SIZE);
  endfunction

  // Write strobe aimed at one register index
  function automatic logic wr_hit(input logic wr, input logic [15:0] at, input logic [15:0] want);
    wr_hit = wr && (at == want);
  endfunction

  // Register decode
  logic bus_req;            // New request this cycle
  logic bus_wr;             // Byte-lane write this cycle
  logic [15:0] idx;         // Register index
  logic [ADDR_W-1:0] hold; // Array read address
  logic [11:0] por_len;     // Chosen hold length
  logic [7:0] opt_byte;     // Options as read
  logic [7:0] ctl_byte;     // Control as read
  logic [7:0] sts_byte;     // Status as read
  logic lo_in;              // Written value of latch bit
  logic pg_in;              // Written value of program bit

  // Request decode; writes need only the low byte lane select, and the address write takes bus bits above it too
  always_comb
  begin
    bus_req = cyc_i && stb_i && !st_r.ack;
    bus_wr = bus_req && we_i && sel_i[0];
    idx = 16'(adr_i[15:2]);
    hold = st_r.addr;
    lo_in = dat_i[`CTL_LAT_BIT];
    pg_in = dat_i[`CTL_PGM_BIT];
    // Short hold when the option bit is set
    por_len = st_r.opt.por_hold_select ? `POR_SHORT : `POR_LONG; // RULE14
  end

  // Readback images of the registers
  always_comb
  begin
    // Bit 7 and bit 5 always read zero
    opt_byte = '0; // RULE17
    opt_byte[`OPT_PROT_BIT] = st_r.opt.main_array_protect;
    opt_byte[`OPT_POR_BIT] = st_r.opt.por_hold_select;
    opt_byte[`OPT_WATCHDOG_AFTER_RESET_BIT] = st_r.opt.watchdog_after_reset;
    opt_byte[`OPT_WATCHDOG_IN_WAIT_BIT] = st_r.opt.watchdog_in_wait;
    opt_byte[`OPT_PB_BIT] = st_r.opt.portb_pulldown_enable;
    opt_byte[`OPT_PC_BIT] = st_r.opt.portc_pulldown_enable;
    // Latch and program bits follow the mode
    ctl_byte = '0;
    ctl_byte[`CTL_LAT_BIT] = (st_r.state != PS_READ);
    ctl_byte[`CTL_PGM_BIT] = (st_r.state == PS_BURN);
    ctl_byte[`CTL_EXTERNAL_CLOCK_OUT_ENABLE_BIT] = st_r.external_clock_out_enable;
    // Live status
    sts_byte = '0;
    sts_byte[`STS_SUP_BIT] = st_r.sup_sync[1];
    sts_byte[`STS_GRP_BIT] = st_r.grp_err;
    sts_byte[`STS_PROT_BIT] = st_r.prot_err;
    sts_byte[`STS_BOOT_BIT] = st_r.boot_sync[1];
    sts_byte[`STS_BLK_BIT] = st_r.fetch_blk;
  end

  // Array port: read at the pointer, program from the group
  always_comb
  begin
    aport.rd_addr = hold;
    aport.wr_addr = {st_r.base, st_r.burn_idx};
    aport.wr_data = st_r.gbuf[st_r.burn_idx];
    // Only with the supply present and program enabled
    aport.wr_en = (st_r.state == PS_BURN) && st_r.sup_sync[1] && st_r.vld[st_r.burn_idx]; // RULE6
    // Protect also holds at the cell, in case it was set after latching
    if (st_r.opt.main_array_protect && !in_sec(aport.wr_addr))
    begin
      aport.wr_en = 1'b0; // RULE12 RULE13
    end
  end

  // Next-state logic
  always_comb
  begin
    st_nxt = st_r;

    // Pin synchronisers; only the second stage is used
    st_nxt.sup_sync = {st_r.sup_sync[0], programming_supply_i};
    st_nxt.boot_sync = {st_r.boot_sync[0], boot_mode_i};

    // Bus answer one cycle after the request, dropped next
    st_nxt.ack = bus_req;

    // Read data for the answer
    if (bus_req)
    begin
      unique case (idx)
        `CTL_IDX: st_nxt.rdat = ctl_byte;
        `OPT_IDX: st_nxt.rdat = opt_byte;
        `ADR_IDX: st_nxt.rdat = 8'(st_r.addr);
        `STS_IDX: st_nxt.rdat = sts_byte;
        // Latched array gives no stored data
        `DAT_IDX: st_nxt.rdat = (st_r.state == PS_READ) ? aport.rd_data : `BLOCKED_BYTE; // RULE7
        // Unmapped answers zero
        default: st_nxt.rdat = '0;
      endcase
    end

    // Address pointer, full width over the low bus bits
    if (wr_hit(bus_wr, idx, `ADR_IDX))
    begin
      st_nxt.addr = dat_i[ADDR_W-1:0];
    end

    // Options: writable only in boot mode, bits only set
    if (wr_hit(bus_wr, idx, `OPT_IDX) && st_r.boot_sync[1]) // RULE16
    begin
      st_nxt.opt.main_array_protect |= dat_i[`OPT_PROT_BIT];
      st_nxt.opt.por_hold_select |= dat_i[`OPT_POR_BIT];
      st_nxt.opt.watchdog_after_reset |= dat_i[`OPT_WATCHDOG_AFTER_RESET_BIT];
      st_nxt.opt.watchdog_in_wait |= dat_i[`OPT_WATCHDOG_IN_WAIT_BIT];
      st_nxt.opt.portb_pulldown_enable |= dat_i[`OPT_PB_BIT];
      st_nxt.opt.portc_pulldown_enable |= dat_i[`OPT_PC_BIT];
    end

    // Control register
    if (wr_hit(bus_wr, idx, `CTL_IDX))
    begin
      st_nxt.external_clock_out_enable = dat_i[`CTL_EXTERNAL_CLOCK_OUT_ENABLE_BIT];
      unique case (st_r.state)
        // Latch first; program bit ignored until data is loaded
        PS_READ:
        begin
          if (lo_in)
          begin
            st_nxt.state = PS_LOAD;
            st_nxt.vld = '0;
            st_nxt.grp_err = 1'b0;
            st_nxt.prot_err = 1'b0;
          end
        end
        // Program only once at least one byte is latched
        PS_LOAD:
        begin
          if (!lo_in)
          begin
            st_nxt.state = PS_READ; // RULE10
          end
          else if (pg_in && |st_r.vld)
          begin
            st_nxt.state = PS_BURN;
            st_nxt.burn_idx = '0;
          end
        end
        // Program enable leaves only with the latch
        PS_BURN:
        begin
          if (!lo_in)
          begin
            st_nxt.state = PS_READ; // RULE10
          end
        end
        // Unused code falls back to read mode
        default:
        begin
          st_nxt.state = PS_READ;
        end
      endcase
    end

    // Latching a data byte into the group
    if (wr_hit(bus_wr, idx, `DAT_IDX) && st_r.state == PS_LOAD)
    begin
      if (st_r.opt.main_array_protect && !in_sec(st_r.addr))
      begin
        // Main array locked; secondary stays open
        st_nxt.prot_err = 1'b1; // RULE12 RULE13
      end
      else if (|st_r.vld && st_r.base != st_r.addr[ADDR_W-1:GROUP_BITS])
      begin
        // Upper bits must match the group already held
        st_nxt.grp_err = 1'b1; // RULE3 RULE4
      end
      else
      begin
        st_nxt.gbuf[st_r.addr[GROUP_BITS-1:0]] = dat_i[7:0];
        st_nxt.vld[st_r.addr[GROUP_BITS-1:0]] = 1'b1;
        st_nxt.base = st_r.addr[ADDR_W-GROUP_BITS-1+GROUP_BITS:GROUP_BITS]; // RULE3 RULE4
      end
    end

    // Step through the group while the supply is present
    if (st_r.state == PS_BURN && st_r.sup_sync[1])
    begin
      st_nxt.burn_idx = GROUP_BITS'(st_r.burn_idx + 1'b1);
    end

    // Stop mode wins over any bus write
    if (stop_i)
    begin
      st_nxt.state = PS_READ; // RULE11
    end

    // Power-on hold, then watchdog decision
    if (!st_r.por_n)
    begin
      st_nxt.por_cnt = 12'(st_r.por_cnt + 1'b1);
      if (12'(st_r.por_cnt + 1'b1) >= por_len) // RULE14
      begin
        st_nxt.por_n = 1'b1;
        // Boot mode keeps the watchdog quiet
        st_nxt.wdog = st_r.opt.watchdog_after_reset && !st_r.boot_sync[1]; // RULE15
      end
    end

    // Reset clears everything but the options
    if (rst_i)
    begin
      st_nxt = '0;
      st_nxt.state = PS_READ;
      st_nxt.opt = st_r.opt; // RULE16
    end

    // Output flops follow the next mode in the same edge
    st_nxt.fetch_blk = (st_nxt.state != PS_READ); // RULE5 RULE8 RULE9
    st_nxt.pgm_on = (st_nxt.state == PS_BURN);
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    st_r <= st_nxt;
  end

  // Bus outputs; upper bytes read as zero
  assign dat_o = {24'h00_0000, st_r.rdat};
  assign ack_o = st_r.ack;

  // Core stalls code, vector and boot fetch on this
  assign fetch_block_o = st_r.fetch_blk; // RULE5 RULE8 RULE9
  assign program_active_o = st_r.pgm_on;
  assign ext_clk_out_en_o = st_r.external_clock_out_enable;

  // Reset pin and watchdog
  assign por_reset_n_o = st_r.por_n;
  assign watchdog_run_o = st_r.wdog;
  assign watchdog_in_wait_o = st_r.opt.watchdog_in_wait; // RULE19

  // Port pull-downs
  assign portb_pulldown_enable_o = st_r.opt.portb_pulldown_enable; // RULE18
  assign portc_pulldown_enable_o = st_r.opt.portc_pulldown_enable; // RULE18

endmodule

// >>> pkg/array_port_if.sv
`timescale 1ns/1ps
// Link between the controller and the array storage
interface array_port_if #(
  parameter int ADDR_W = 13
);
  logic [ADDR_W-1:0] rd_addr; // Byte being read
  logic [7:0] rd_data;        // Stored byte
  logic wr_en;                // Program one byte this cycle
  logic [ADDR_W-1:0] wr_addr; // Byte being programmed
  logic [7:0] wr_data;        // Bits to set

  modport ctrl (
    output rd_addr,
    output wr_en,
    output wr_addr,
    output wr_data,
    input rd_data
  );

  modport store (
    input rd_addr,
    input wr_en,
    input wr_addr,
    input wr_data,
    output rd_data
  );
endinterface

// >>> pkg/otp_map.svh
`ifndef OTP_MAP_SVH
`define OTP_MAP_SVH

// Register indices; byte address is four times the index
`define CTL_IDX 16'h0007
`define OPT_IDX 16'h1efe
`define ADR_IDX 16'h0010
`define DAT_IDX 16'h0011
`define STS_IDX 16'h0012

// Control register fields
`define CTL_LAT_BIT 5
`define CTL_PGM_BIT 4
`define CTL_EXTERNAL_CLOCK_OUT_ENABLE_BIT 3

// Option register fields
`define OPT_PROT_BIT 6
`define OPT_POR_BIT 4
`define OPT_WATCHDOG_AFTER_RESET_BIT 3
`define OPT_WATCHDOG_IN_WAIT_BIT 2
`define OPT_PB_BIT 1
`define OPT_PC_BIT 0

// Status register fields
`define STS_SUP_BIT 0
`define STS_GRP_BIT 1
`define STS_PROT_BIT 2
`define STS_BOOT_BIT 3
`define STS_BLK_BIT 4

// Array data values
`define ERASED_BYTE 8'h00
`define BLOCKED_BYTE 8'hff

// Power-on hold lengths in clock cycles
`define POR_SHORT 12'h0010
`define POR_LONG 12'h0fe0

`endif

// >>> pkg/otp_pkg.sv
package otp_pkg;

  // Array mode: read, loading a group, programming
  typedef enum logic [1:0] {PS_READ, PS_LOAD, PS_BURN} prog_e;

  // Nonvolatile option bits
  typedef struct packed {
    logic main_array_protect;
    logic por_hold_select;
    logic watchdog_after_reset;
    logic watchdog_in_wait;
    logic portb_pulldown_enable;
    logic portc_pulldown_enable;
  } opt_s;

endpackage

// >>> testbench/otp_ctl_checker.sv
`timescale 1ns/1ps
`include "otp_map.svh"
module otp_ctl_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Core side
  input wire logic stop_i,
  input wire logic fetch_block_o,
  input wire logic program_active_o,
  input wire logic por_reset_n_o,
  input wire logic watchdog_run_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken at this edge
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  // Control write with stop absent
  sequence s_ctl_wr;
    cyc_i && stb_i && !ack_o && we_i && sel_i[0] && adr_i[15:2] == `CTL_IDX && !stop_i;
  endsequence
  // Read of one register
  sequence s_rd(idx);
    cyc_i && stb_i && !ack_o && !we_i && adr_i[15:2] == idx;
  endsequence
  chk_ack_next: assert property (s_take |=> ack_o) else $error("ack late");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_latch_set: assert property (s_ctl_wr ##0 dat_i[`CTL_LAT_BIT] |-> ##[1:2] fetch_block_o)
    else $error("latch not set");
  chk_latch_clear: assert property (s_ctl_wr ##0 !dat_i[`CTL_LAT_BIT] |-> ##[1:2] !fetch_block_o && !program_active_o)
    else $error("latch clear kept program");
  chk_pgm_in_latch: assert property (program_active_o |-> fetch_block_o) else $error("program without latch");
  chk_stop_read: assert property (stop_i |-> ##[1:2] !fetch_block_o && !program_active_o)
    else $error("stop kept latch");
  chk_read_blocked: assert property (s_rd(`DAT_IDX) ##0 fetch_block_o |=> dat_o[7:0] == `BLOCKED_BYTE)
    else $error("latched read gave data");
  chk_opt_bit7: assert property (s_rd(`OPT_IDX) |=> !dat_o[7] && !dat_o[5]) else $error("option bit7 set");
  chk_wdog_por: assert property ($rose(watchdog_run_o) |-> $rose(por_reset_n_o))
    else $error("watchdog start off hold end");
  chk_por_stays: assert property ($fell(por_reset_n_o) |-> $past(rst_i)) else $error("reset pin fell");
endmodule

bind otp_eprom_program_control otp_ctl_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .stop_i(stop_i), .fetch_block_o(fetch_block_o), .program_active_o(program_active_o),
  .por_reset_n_o(por_reset_n_o), .watchdog_run_o(watchdog_run_o));

// >>> testbench/otp_eprom_program_control_bench.sv
`timescale 1ns/1ps
`include "otp_map.svh"
module otp_eprom_program_control_bench;
  localparam int SEC_BASE = 5950;
  // Design inputs
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, stop_i = 0, boot_i = 0;
  logic [15:0] adr_i = 0;
  logic [3:0] sel_i = 0, dly = 0;
  logic [31:0] dat_i = 0;
  // Design outputs
  logic [31:0] dat_o;
  logic ack_o, supply, fblk, pact, clko, por_n, wdog, wwait, pb_pd, pc_pd;
  // Reference model: array bytes and option bits
  bit [7:0] mem [int];
  logic [7:0] opt = 0, q, d;
  int n_fail = 0, comparisons = 0, n, base;

  otp_eprom_program_control #(.SEC_BASE(SEC_BASE)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .stop_i(stop_i), .boot_mode_i(boot_i), .programming_supply_i(supply), .fetch_block_o(fblk),
    .program_active_o(pact), .ext_clk_out_en_o(clko), .por_reset_n_o(por_n), .watchdog_run_o(wdog),
    .watchdog_in_wait_o(wwait), .portb_pulldown_enable_o(pb_pd), .portc_pulldown_enable_o(pc_pd));
  supply_board i_board (.clk_i(clk_i), .prog_en_i(pact), .delay_i(dly), .supply_o(supply));

  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task finish_test;
    $display("Mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Classic Wishbone cycle; waits for ack, a hang is left to the watchdog
  task wb(input logic w, input logic [15:0] idx, input logic [31:0] v);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    sel_i <= 4'hf;
    adr_i <= idx << 2;
    dat_i <= v;
    do
    begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 0;
    stb_i <= 0;
  endtask

  // Reset, then count cycles until the reset pin releases
  task do_reset(input logic bt);
    boot_i <= bt;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      #1;
    end while (por_n !== 1'b1 && n < 5000);
    check(n, opt[4] ? 16 : 4064);
    check(wdog, opt[3] && !bt);
    wb(0, `OPT_IDX, 0);
    check(q, opt);
  endtask

  // Latch, load a group, switch on programming, return to read mode
  task burn(input int a);
    wb(1, `CTL_IDX, 32'h0000_0020);
    wb(0, `DAT_IDX, 0);
    check(q, `BLOCKED_BYTE);
    check(fblk, 1);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom;
      wb(1, `ADR_IDX, a + i);
      wb(1, `DAT_IDX, d);
      mem[a + i] = mem[a + i] | d;
    end
    dly <= $urandom;
    wb(1, `CTL_IDX, 32'h0000_0030);
    // Board switches the supply in; only the watchdog ends a hang here
    do
    begin
      @(posedge clk_i);
    end while (supply !== 1'b1);
    repeat (20) @(posedge clk_i);
    wb(0, `CTL_IDX, 0);
    check(q, 8'h30);
    wb(1, `CTL_IDX, 0);
    repeat (2) @(posedge clk_i);
    check({pact, fblk}, 0);
    wb(0, `CTL_IDX, 0);
    check(q, 0);
  endtask

  // Read one array byte back
  task peek(input int a);
    wb(1, `ADR_IDX, a);
    wb(0, `DAT_IDX, 0);
    check(q, mem[a]);
  endtask

  initial
  begin
    void'($urandom(24326));
    do_reset(0);
    wb(1, `OPT_IDX, 32'h0000_001f);
    wb(0, `OPT_IDX, 0);
    check(q, 0);
    boot_i <= 1;
    repeat (3) @(posedge clk_i);
    opt = 8'h18 | ($urandom & 8'h07);
    wb(1, `OPT_IDX, opt | 8'ha0);
    wb(0, `OPT_IDX, 0);
    check(q, opt);
    check({wwait, pb_pd, pc_pd}, opt[2:0]);
    do_reset(1);
    do_reset(0);
    base = ($urandom % 1400) * 4;
    peek(base);
    burn(base);
    burn(base);
    for (int i = 0; i < 4; i++)
      peek(base + i);
    // Byte outside the group is refused; clock-out bit rides along
    wb(1, `CTL_IDX, 32'h0000_0028);
    wb(1, `ADR_IDX, base);
    wb(1, `DAT_IDX, 1);
    wb(1, `ADR_IDX, base + 4);
    wb(1, `DAT_IDX, 2);
    wb(0, `STS_IDX, 0);
    check(q[1], 1);
    stop_i <= 1;
    @(posedge clk_i);
    stop_i <= 0;
    repeat (2) @(posedge clk_i);
    check(fblk, 0);
    // Stop drops latch and program only; clock-out stays
    wb(0, `CTL_IDX, 0);
    check(q, 8'h08);
    check({clko, pact}, 2'b10);
    // Protect the main array, secondary stays writable
    boot_i <= 1;
    repeat (3) @(posedge clk_i);
    opt = opt | 8'h40;
    wb(1, `OPT_IDX, opt);
    boot_i <= 0;
    wb(1, `CTL_IDX, 32'h0000_0020);
    wb(1, `ADR_IDX, base);
    wb(1, `DAT_IDX, 32'h0000_00ff);
    wb(0, `STS_IDX, 0);
    check(q[2], 1);
    wb(1, `CTL_IDX, 0);
    peek(base);
    base = SEC_BASE + 2 + 4 * ($urandom % 60);
    burn(base);
    for (int i = 0; i < 4; i++)
      peek(base + i);
    finish_test;
  end

  // Hang guard
  initial
  begin
    #300000;
    n_fail++;
    finish_test;
  end
endmodule

// >>> testbench/supply_board.sv
`timescale 1ns/1ps
// Programming board that switches the array supply
module supply_board (
  // Clock
  input wire logic clk_i,
  // Program enable seen on the routine's pin, switching delay
  input wire logic prog_en_i,
  input wire logic [3:0] delay_i,
  // Switched supply
  output logic supply_o
);
  int cnt = 0;
  // Supply comes up only after enable is seen, slow or prompt
  always @(posedge clk_i)
  begin
    if (!prog_en_i)
    begin
      cnt <= 0;
      supply_o <= 1'b0;
    end
    else if (cnt >= delay_i)
      supply_o <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule
